// [hdl/tso_engine.sv]
// transmit segmentation offload engine: prototype header store, per-frame
// header rewrite, vlan insertion and checksum generation
// assumes descriptor dma delivers header then payload bytes on in_*,
// and the packet buffer behind out_* applies patch_* to the frame just sent
`timescale 1ns/1ps
`default_nettype none
module tso_engine #(
  parameter logic [15:0] VLAN_ETHER_TYPE = tso_pkg::VLAN_TYPE_DEFAULT
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // context and first data descriptor
  input wire logic start_valid,
  output logic start_ready,
  input wire tso_pkg::tso_ctx_s start_ctx,
  input wire tso_pkg::tso_desc_s start_desc,
  output logic desc_reject,
  // fetched header and payload bytes
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  // frame stream to the transmit path
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  output logic out_last,
  // checksum results for the frame just sent
  output logic patch_valid,
  output tso_pkg::tso_patch_s patch,
  // status
  output logic busy
);
  import tso_pkg::*;

  tso_state_e st_q;
  tso_ctx_s ctx_q;
  logic [7:0] hdr_mem [HDR_BUF_BYTES];
  logic vlan_en_q;
  logic [15:0] vlan_tag_q;
  logic [7:0] hidx_q;
  logic [2:0] vcnt_q;
  logic [15:0] seg_cnt_q;
  logic [19:0] rem_q;
  logic [15:0] id_q;
  logic [31:0] seq_q;
  logic pend_q;
  logic patch_valid_q;
  tso_patch_s patch_q;

  // descriptor recognition
  logic desc_ok;
  logic start_fire;
  assign desc_ok = start_desc.ctl[DESC_EXT_BIT]
                   && start_desc.ctl[DESC_TYPE_LSB +: 4] == DESC_TYPE_DATA;
  assign start_ready = st_q == ST_IDLE;
  assign start_fire = start_valid && start_ready;
  assign desc_reject = start_fire && !desc_ok;
  assign busy = st_q != ST_IDLE;

  // segment sizing; the last frame takes whatever remains
  logic last_seg;
  logic [15:0] seg_pay;
  logic [15:0] len_base;
  logic [15:0] snap_len;
  logic [15:0] ip_len;
  logic [15:0] l4_len;
  assign last_seg = rem_q <= {4'h0, ctx_q.mss};
  assign seg_pay = last_seg ? rem_q[15:0] : ctx_q.mss;
  assign len_base = seg_pay + {8'h00, ctx_q.hdr_len};
  assign snap_len = len_base - ETH_HDR_BYTES;
  assign ip_len = ctx_q.ip_v4 ? len_base - {8'h00, ctx_q.ip_css}
                  : len_base - {8'h00, ctx_q.ip_css} - IPV6_HDR_BYTES;
  assign l4_len = len_base - {8'h00, ctx_q.tu_css};

  // header byte position decode
  logic [7:0] rel_ip;
  logic [7:0] rel_l4;
  logic in_ip;
  logic in_l4;
  logic vlan_slot;
  assign rel_ip = hidx_q - ctx_q.ip_css;
  assign rel_l4 = hidx_q - ctx_q.tu_css;
  assign in_ip = hidx_q >= ctx_q.ip_css && hidx_q < ctx_q.tu_css;
  assign in_l4 = hidx_q >= ctx_q.tu_css;
  assign vlan_slot = vlan_en_q && hidx_q == MAC_ADDR_BYTES && vcnt_q < VLAN_BYTES;

  // per-frame rewrite of the stored prototype
  logic [7:0] proto_b;
  logic [7:0] mod_b;
  logic [31:0] vlan_word;
  logic [7:0] flag_mask;
  assign flag_mask = (8'h01 << FIN_BIT) | (8'h01 << PSH_BIT);
  assign proto_b = hdr_mem[hidx_q];
  assign vlan_word = {VLAN_ETHER_TYPE, vlan_tag_q};
  assign mod_b =
    vlan_slot ? vlan_word[8'(31 - 8 * vcnt_q) -: 8] :
    (ctx_q.snap && hidx_q == SNAP_LEN_OFF) ? snap_len[15:8] :
    (ctx_q.snap && hidx_q == SNAP_LEN_OFF + 8'h01) ? snap_len[7:0] :
    (in_ip && ctx_q.ip_v4 && rel_ip == IP_LEN_OFF) ? ip_len[15:8] :
    (in_ip && ctx_q.ip_v4 && rel_ip == IP_LEN_OFF + 8'h01) ? ip_len[7:0] :
    (in_ip && !ctx_q.ip_v4 && rel_ip == IPV6_LEN_OFF) ? ip_len[15:8] :
    (in_ip && !ctx_q.ip_v4 && rel_ip == IPV6_LEN_OFF + 8'h01) ? ip_len[7:0] :
    (in_ip && ctx_q.ip_v4 && rel_ip == IP_ID_OFF) ? id_q[15:8] :
    (in_ip && ctx_q.ip_v4 && rel_ip == IP_ID_OFF + 8'h01) ? id_q[7:0] :
    (in_l4 && ctx_q.is_tcp && rel_l4 >= TCP_SEQ_OFF && rel_l4 < TCP_SEQ_OFF + 8'h04) ?
      seq_q[8'(31 - 8 * (rel_l4 - TCP_SEQ_OFF)) -: 8] :
    (in_l4 && ctx_q.is_tcp && rel_l4 == TCP_FLAGS_OFF) ?
      (last_seg ? proto_b : proto_b & ~flag_mask) :
    (in_l4 && !ctx_q.is_tcp && rel_l4 == UDP_LEN_OFF) ? l4_len[15:8] :
    (in_l4 && !ctx_q.is_tcp && rel_l4 == UDP_LEN_OFF + 8'h01) ? l4_len[7:0] :
    proto_b;

  // stream handshake; payload bytes pass straight from the fetch side
  logic hdr_phase;
  logic hdr_fire;
  logic pay_fire;
  logic hdr_done;
  logic seg_end;
  assign hdr_phase = st_q == ST_HDR && !pend_q;
  assign out_valid = hdr_phase || (st_q == ST_PAY && in_valid);
  assign out_data = hdr_phase ? mod_b : in_data;
  assign in_ready = st_q == ST_LOAD || (st_q == ST_PAY && out_ready);
  assign hdr_fire = hdr_phase && out_ready && !vlan_slot;
  assign pay_fire = st_q == ST_PAY && in_valid && out_ready;
  assign hdr_done = hdr_fire && hidx_q == ctx_q.hdr_len - 8'h01;
  assign seg_end = (hdr_done && seg_pay == 16'h0000)
                   || (pay_fire && seg_cnt_q == seg_pay - 16'h0001);
  assign out_last = out_valid && (st_q == ST_PAY ? seg_cnt_q == seg_pay - 16'h0001
                    : !vlan_slot && hidx_q == ctx_q.hdr_len - 8'h01 && seg_pay == 16'h0000);

  // checksum feeds cover header bytes as sent, options included
  logic [15:0] pos;
  logic [15:0] ip_sum;
  logic [15:0] l4_sum;
  logic acc_clear;
  logic [15:0] ip_rel16;
  logic [15:0] l4_rel16;
  assign pos = st_q == ST_PAY ? {8'h00, ctx_q.hdr_len} + seg_cnt_q : {8'h00, hidx_q};
  assign ip_rel16 = pos - {8'h00, ctx_q.ip_css};
  assign l4_rel16 = pos - {8'h00, ctx_q.tu_css};
  assign acc_clear = st_q == ST_LOAD || pend_q;

  tso_csum_acc u_ip_acc (
    .clock(clock),
    .reset(reset),
    .clear(acc_clear),
    .en(hdr_fire && in_ip),
    .hi(!ip_rel16[0]),
    .data(mod_b),
    .sum(ip_sum)
  );

  tso_csum_acc u_l4_acc (
    .clock(clock),
    .reset(reset),
    .clear(acc_clear),
    .en((hdr_fire && in_l4) || pay_fire),
    .hi(!l4_rel16[0]),
    .data(out_data),
    .sum(l4_sum)
  );

  // one ip and one l4 result per frame; the l4 length completes the pseudo header
  tso_patch_s patch_d;
  assign patch_d.ip_en = ctx_q.ixsm && ctx_q.ip_v4;
  assign patch_d.ip_off = ctx_q.ip_css + IP_CSUM_OFF;
  assign patch_d.ip_csum = ~ip_sum;
  assign patch_d.l4_en = ctx_q.txsm;
  assign patch_d.l4_off = ctx_q.tu_css + (ctx_q.is_tcp ? TCP_CSUM_OFF : UDP_CSUM_OFF);
  assign patch_d.l4_csum = ~csum_fold({16'h0000, l4_sum} + {16'h0000, l4_len});
  assign patch_valid = patch_valid_q;
  assign patch = patch_q;

  // prototype capture, once per context
  always_ff @(posedge clock) begin
    if (st_q == ST_LOAD && in_valid && hidx_q < 8'(HDR_BUF_BYTES)) begin
      hdr_mem[hidx_q] <= in_data;
    end
  end

  // sequencing of one context
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_q <= ST_IDLE;
      ctx_q <= '0;
      vlan_en_q <= 1'b0;
      vlan_tag_q <= 16'h0000;
      hidx_q <= 8'h00;
      vcnt_q <= 3'h0;
      seg_cnt_q <= 16'h0000;
      rem_q <= 20'h0_0000;
      id_q <= 16'h0000;
      seq_q <= 32'h0000_0000;
      pend_q <= 1'b0;
      patch_valid_q <= 1'b0;
      patch_q <= '0;
    end else begin
      patch_valid_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (start_fire && desc_ok) begin
            st_q <= ST_LOAD;
            ctx_q <= start_ctx;
            rem_q <= start_ctx.paylen;
            vlan_en_q <= start_desc.ctl[DESC_VLAN_BIT];
            vlan_tag_q <= start_desc.ctl[DESC_VLAN_BIT] ? start_desc.vlan_tag
                          : 16'h0000;
            hidx_q <= 8'h00;
            vcnt_q <= 3'h0;
          end
        end
        ST_LOAD: begin
          if (in_valid) begin
            // first-frame identification and sequence come from the prototype
            if (hidx_q == ctx_q.ip_css + IP_ID_OFF
                || hidx_q == ctx_q.ip_css + IP_ID_OFF + 8'h01) begin
              id_q <= {id_q[7:0], in_data};
            end
            if (hidx_q >= ctx_q.tu_css + TCP_SEQ_OFF
                && hidx_q < ctx_q.tu_css + TCP_SEQ_OFF + 8'h04) begin
              seq_q <= {seq_q[23:0], in_data};
            end
            hidx_q <= hidx_q + 8'h01;
            if (hidx_q == ctx_q.hdr_len - 8'h01) begin
              st_q <= ST_HDR;
              hidx_q <= 8'h00;
            end
          end
        end
        ST_HDR: begin
          if (pend_q) begin
            // close the frame just sent and step the per-frame fields
            pend_q <= 1'b0;
            patch_valid_q <= 1'b1;
            patch_q <= patch_d;
            rem_q <= rem_q - {4'h0, seg_pay};
            id_q <= id_q + 16'h0001;
            seq_q <= seq_q + {16'h0000, ctx_q.mss};
            if (last_seg) st_q <= ST_IDLE;
          end else if (vlan_slot && out_ready) begin
            vcnt_q <= vcnt_q + 3'h1;
          end else if (hdr_fire) begin
            hidx_q <= hidx_q + 8'h01;
            if (hdr_done && seg_pay != 16'h0000) st_q <= ST_PAY;
          end
          if (!pend_q && seg_end) begin
            pend_q <= 1'b1;
            hidx_q <= 8'h00;
            vcnt_q <= 3'h0;
          end
        end
        ST_PAY: begin
          if (pay_fire) seg_cnt_q <= seg_cnt_q + 16'h0001;
          if (seg_end) begin
            st_q <= ST_HDR;
            pend_q <= 1'b1;
            hidx_q <= 8'h00;
            vcnt_q <= 3'h0;
            seg_cnt_q <= 16'h0000;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_frame_close;
    pend_q && !last_seg ##1 st_q == ST_HDR;
  endsequence

  a_reject_stays_idle: assert property (
    start_valid && st_q == ST_IDLE && !desc_ok |=> st_q == ST_IDLE)
    else $error("unrecognised descriptor started a context");
  a_no_refetch: assert property (
    st_q == ST_HDR |-> !in_ready)
    else $error("header refetched after load");
  a_seg_bound: assert property (
    pay_fire |-> seg_cnt_q < ctx_q.mss)
    else $error("frame payload exceeds mss");
  a_flags_cleared: assert property (
    hdr_fire && ctx_q.is_tcp && in_l4 && rel_l4 == TCP_FLAGS_OFF && !last_seg
    |-> out_data[FIN_BIT] == 1'b0 && out_data[PSH_BIT] == 1'b0)
    else $error("fin or psh sent before last frame");
  a_id_step: assert property (
    pend_q && !last_seg |=> id_q == $past(id_q) + 16'h0001)
    else $error("ip identification not incremented");
  a_seq_step: assert property (
    s_frame_close |-> seq_q == $past(seq_q) + {16'h0000, ctx_q.mss})
    else $error("sequence not advanced by mss");
  a_patch_after_last: assert property (
    out_valid && out_ready && out_last |=> ##1 patch_valid)
    else $error("no checksum result after frame end");
  a_vlan_off: assert property (
    !vlan_en_q |-> vcnt_q == 3'h0 && vlan_tag_q == 16'h0000)
    else $error("vlan tag used while insertion disabled");
  a_no_ipv6_csum: assert property (
    patch_valid |-> !(patch.ip_en && !ctx_q.ip_v4))
    else $error("ip checksum requested for ipv6");
  a_ipv4_len: assert property (
    hdr_fire && in_ip && ctx_q.ip_v4 && rel_ip == IP_LEN_OFF && !last_seg
    |-> out_data == 8'(({8'h00, ctx_q.hdr_len} + ctx_q.mss - {8'h00, ctx_q.ip_css}) >> 8))
    else $error("ipv4 total length wrong on full frame");
endmodule
`default_nettype wire

// [hdl/tso_pkg.sv]
// package for the transmit segmentation offload engine
// assumes one context at a time and a byte-wide transmit stream
package tso_pkg;

  // on-chip prototype header store
  localparam int HDR_BUF_BYTES = 240;

  // descriptor control word layout
  localparam int DESC_EXT_BIT = 29;
  localparam int DESC_VLAN_BIT = 30;
  localparam int DESC_TYPE_LSB = 20;
  localparam logic [3:0] DESC_TYPE_DATA = 4'h1;

  // header field offsets and sizes in bytes
  localparam logic [7:0] MAC_ADDR_BYTES = 8'h0c;
  localparam logic [7:0] SNAP_LEN_OFF = 8'h0c;
  localparam logic [15:0] ETH_HDR_BYTES = 16'h000e;
  localparam logic [15:0] IPV6_HDR_BYTES = 16'h0028;
  localparam logic [7:0] IP_LEN_OFF = 8'h02;
  localparam logic [7:0] IP_ID_OFF = 8'h04;
  localparam logic [7:0] IPV6_LEN_OFF = 8'h04;
  localparam logic [7:0] TCP_SEQ_OFF = 8'h04;
  localparam logic [7:0] TCP_FLAGS_OFF = 8'h0d;
  localparam logic [7:0] UDP_LEN_OFF = 8'h04;
  localparam logic [7:0] IP_CSUM_OFF = 8'h0a;
  localparam logic [7:0] TCP_CSUM_OFF = 8'h10;
  localparam logic [7:0] UDP_CSUM_OFF = 8'h06;
  localparam logic [2:0] VLAN_BYTES = 3'h4;
  localparam int FIN_BIT = 0;
  localparam int PSH_BIT = 3;
  localparam logic [15:0] VLAN_TYPE_DEFAULT = 16'h8100;

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_HDR, ST_PAY} tso_state_e;

  // segmentation context, taken together with the first data descriptor
  typedef struct packed {
    logic [15:0] mss;
    logic [19:0] paylen;
    logic [7:0] hdr_len;
    logic [7:0] ip_css;
    logic [7:0] tu_css;
    logic ip_v4;
    logic is_tcp;
    logic ixsm;
    logic txsm;
    logic snap;
  } tso_ctx_s;

  typedef struct packed {
    logic [31:0] ctl;
    logic [15:0] vlan_tag;
  } tso_desc_s;

  // checksum results for the frame just sent
  typedef struct packed {
    logic ip_en;
    logic [7:0] ip_off;
    logic [15:0] ip_csum;
    logic l4_en;
    logic [7:0] l4_off;
    logic [15:0] l4_csum;
  } tso_patch_s;

  // ones-complement fold of a wide sum
  function automatic logic [15:0] csum_fold(input logic [31:0] a);
    logic [16:0] s;
    s = {1'b0, a[15:0]} + {1'b0, a[31:16]};
    s = {1'b0, s[15:0]} + {16'h0000, s[16]};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

endpackage

// [hdl/tso_csum_acc.sv]
// running ones-complement accumulator of a byte stream
// assumes the caller marks which byte is the high half of a word
`timescale 1ns/1ps
`default_nettype none
module tso_csum_acc (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // byte stream
  input wire logic clear,
  input wire logic en,
  input wire logic hi,
  input wire logic [7:0] data,
  // folded sum
  output logic [15:0] sum
);
  import tso_pkg::*;

  logic [31:0] acc_q;
  logic [31:0] acc_d;

  // wide accumulator, carries folded only at the end; 32 bits covers any frame
  assign acc_d = clear ? 32'h0000_0000 :
                 en ? acc_q + (hi ? {16'h0000, data, 8'h00} : {24'h00_0000, data}) : acc_q;
  assign sum = csum_fold(acc_q);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) acc_q <= 32'h0000_0000;
    else acc_q <= acc_d;
  end
endmodule
`default_nettype wire

// [bench/tso_host_model.sv]
// host driver and memory model: builds one prototype header, streams it, then the payload
// assumes the engine samples in_valid and in_ready on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module tso_host_model #(
  parameter logic [15:0] ID0 = 16'hfffe,
  parameter logic [31:0] SEQ0 = 32'h0000_1000,
  parameter logic [15:0] PSUM = 16'h1234
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // job control
  input wire logic go,
  input wire logic slow,
  input wire logic [7:0] total,
  output logic [7:0] sent,
  // byte stream to the engine
  output logic in_valid,
  input wire logic in_ready,
  output logic [7:0] in_data
);
  logic [7:0] mem [0:127];
  logic acc_q;
  logic go_q;
  logic tick_q;
  logic [7:0] nx;
  logic v;

  // plain ipv4/tcp prototype in one buffer, no tunnel, sent with context + extended descriptor
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = (i < 54) ? 8'(i + 48) : (8'(i - 54) ^ 8'ha0);
    end
    {mem[12], mem[13], mem[14]} = 24'h0800_45;
    mem[23] = 8'h06;
    {mem[16], mem[17]} = 16'h0000;
    {mem[18], mem[19]} = ID0;
    {mem[24], mem[25]} = 16'h0000;
    {mem[38], mem[39], mem[40], mem[41]} = SEQ0;
    mem[47] = 8'h19;
    {mem[50], mem[51]} = PSUM;
  end

  // acceptance is only known at the rising edge; go is taken there too, so that
  // a change of it at the falling edge never races the offer below
  always @(posedge clock) begin
    acc_q <= in_valid && in_ready;
    go_q <= go;
  end

  // a byte is held until taken; a slow host starts a new offer on every other cycle only
  always @(negedge clock) begin
    nx = sent + 8'(acc_q);
    v = go_q && !reset && (nx < total) && (!slow || tick_q || (in_valid && !acc_q));
    tick_q <= reset ? 1'b0 : ~tick_q;
    sent <= (reset || !go_q) ? 8'h00 : nx;
    in_valid <= v;
    in_data <= v ? mem[nx[6:0]] : ~in_data; // idle line inverts each cycle, so it shows the last byte every other cycle
  end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// testbench for the segmentation engine: host model feeds bytes, frames are rebuilt and judged
// assumes one context at a time and patch results two cycles after each frame
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tso_pkg::*;
  logic clock, reset, start_valid, start_ready, desc_reject, in_valid, in_ready;
  logic out_valid, out_ready, out_last, patch_valid, busy, go, slow;
  logic [7:0] in_data, out_data, total, sent;
  tso_ctx_s ctx;
  tso_desc_s desc;
  tso_patch_s patch;
  tso_patch_s pq [$];
  logic [7:0] ob [$];
  logic [7:0] lf [$];
  logic [7:0] ex [$];
  int flen [$];
  int n_errors, compares;

  tso_engine i_tso_engine (.clock(clock), .reset(reset), .start_valid(start_valid),
    .start_ready(start_ready), .start_ctx(ctx), .start_desc(desc), .desc_reject(desc_reject),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_last(out_last),
    .patch_valid(patch_valid), .patch(patch), .busy(busy));
  tso_host_model i_tso_host_model (.clock(clock), .reset(reset), .go(go), .slow(slow),
    .total(total), .sent(sent), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data));

  always #5 clock = ~clock;

  // transmit path stalls every other cycle in slow runs
  always @(negedge clock) begin
    out_ready <= (slow && out_ready === 1'b1) ? 1'b0 : 1'b1;
  end

  // frame bytes and patch results collected as they are taken
  always @(posedge clock) begin
    if (out_valid && out_ready) begin
      ob.push_back(out_data);
      if (out_last) begin
        flen.push_back(ob.size());
      end
    end
    if (patch_valid) begin
      pq.push_back(patch);
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // complement of the ones-complement sum of lf[lo..hi) taken as big-endian words, plus an extra term
  function automatic logic [15:0] ocsum(input int lo, input int hi, input logic [31:0] add);
    logic [31:0] s;
    s = add;
    for (int i = lo; i < hi; i += 2) begin
      s += {16'h0000, lf[i], (i + 1 < hi) ? lf[i + 1] : 8'h00};
    end
    while (s[31:16] != 16'h0000) begin
      s = {16'h0000, s[15:0]} + {16'h0000, s[31:16]};
    end
    return ~s[15:0];
  endfunction

  task automatic final_report;
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // bad extension bit or bad type is refused and the engine stays idle
  task automatic bad_desc;
    logic [31:0] bad [2] = '{32'h0010_0000, 32'h2020_0000};
    foreach (bad[j]) begin
      @(negedge clock);
      desc = '{ctl: bad[j], vlan_tag: 16'h0000};
      start_valid = 1'b1;
      #1 check(32'(desc_reject), 32'h0000_0001);
      @(negedge clock);
      start_valid = 1'b0;
      check(32'({busy, in_ready}), 32'h0000_0000);
    end
  endtask

  // one whole context; every frame rebuilt from the prototype and compared byte by byte
  // alt recasts the same prototype bytes as a snap, ipv6, udp context
  task automatic run_tso(input logic [15:0] mss, input logic [7:0] pay, input logic vlan_insert_enable,
                         input logic slw, input logic alt);
    int b0, len, p, nfr, w;
    logic [15:0] tl;
    logic [31:0] sq;
    ob.delete();
    flen.delete();
    pq.delete();
    nfr = (pay == 8'h00) ? 1 : (int'(pay) + int'(mss) - 1) / int'(mss);
    @(negedge clock);
    ctx = '{mss: mss, paylen: 20'(pay), hdr_len: 8'h36, ip_css: 8'h0e, tu_css: 8'h22,
            ip_v4: !alt, is_tcp: !alt, ixsm: 1'b1, txsm: 1'b1, snap: alt};
    desc = '{ctl: {1'b0, vlan_insert_enable, 30'h2010_0000}, vlan_tag: 16'hb123};
    total = 8'h36 + pay;
    slow = slw;
    go = 1'b1;
    start_valid = 1'b1;
    #1 check(32'(desc_reject), 32'h0000_0000);
    @(negedge clock);
    start_valid = 1'b0;
    check(32'({busy, start_ready}), 32'h0000_0002);
    w = 0;
    while (busy === 1'b1 && w < 3000) begin
      @(negedge clock);
      w++;
    end
    check(32'(busy), 32'h0000_0000);
    repeat (4) @(negedge clock);
    go = 1'b0;
    check(32'(sent), 32'(total));
    check(32'(flen.size()), 32'(nfr));
    check(32'(pq.size()), 32'(nfr));
    for (int k = 0; k < nfr && k < flen.size() && k < pq.size(); k++) begin
      b0 = (k == 0) ? 0 : flen[k - 1];
      len = flen[k] - b0;
      p = (int'(pay) - k * int'(mss) < int'(mss)) ? int'(pay) - k * int'(mss) : int'(mss);
      check(32'(len), 32'(54 + p + (vlan_insert_enable ? 4 : 0)));
      if (vlan_insert_enable) begin
        check({ob[b0 + 12], ob[b0 + 13], ob[b0 + 14], ob[b0 + 15]}, 32'h8100_b123);
      end
      lf.delete();
      ex.delete();
      for (int i = 0; i < len; i++) begin
        if (!(vlan_insert_enable && i >= 12 && i < 16)) begin
          lf.push_back(ob[b0 + i]);
        end
      end
      for (int i = 0; i < 54 + p; i++) begin
        ex.push_back(i_tso_host_model.mem[(i < 54) ? i : i + k * int'(mss)]);
      end
      tl = 16'(p + 40);
      sq = i_tso_host_model.SEQ0 + 32'(k) * 32'(mss);
      if (alt) begin
        {ex[12], ex[13]} = 16'(p + 40);
        {ex[18], ex[19]} = 16'(p);
        {ex[38], ex[39]} = 16'(p + 20);
      end else begin
        {ex[16], ex[17]} = tl;
        {ex[18], ex[19]} = i_tso_host_model.ID0 + 16'(k);
        {ex[38], ex[39], ex[40], ex[41]} = sq;
        ex[47] = (k == nfr - 1) ? 8'h19 : 8'h10;
      end
      for (int i = 0; i < ex.size() && i < lf.size(); i++) begin
        check(32'(lf[i]), 32'(ex[i]));
      end
      check(32'({pq[k].ip_en, pq[k].ip_off, pq[k].l4_en, pq[k].l4_off}),
            alt ? 32'h0000_3128 : 32'h0002_3132);
      check(32'(pq[k].ip_csum), 32'(ocsum(14, 34, 32'h0)));
      check(32'(pq[k].l4_csum), 32'(ocsum(34, lf.size(), 32'(lf.size() - 34))));
    end
  endtask

  // far longer than the four runs need
  initial begin
    #300_000;
    n_errors++;
    final_report();
  end

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    start_valid = 1'b0;
    go = 1'b0;
    slow = 1'b0;
    total = 8'h00;
    ctx = '0;
    desc = '0;
    n_errors = 0;
    compares = 0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    bad_desc();
    run_tso(16'h0008, 8'h14, 1'b0, 1'b0, 1'b0);
    run_tso(16'h0008, 8'h10, 1'b1, 1'b1, 1'b0);
    run_tso(16'h0010, 8'h05, 1'b0, 1'b1, 1'b0);
    run_tso(16'h0008, 8'h0b, 1'b0, 1'b1, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
